// ---- verilog/mcrd_top.sv ----
`timescale 1ns/100ps
module mcrd_top (
  input  wire logic                                 clock_in,
  input  wire logic                                 rstn_in,
  input  wire logic                                 clk_en_in,
  input  wire logic                                 ext_txmac_pll_in,
  input  wire logic                                 sync_ethernet_option_in,
  input  wire logic                                 four_lane_in,
  input  wire logic                                 reconfig_family_in,
  input  wire logic                                 int_txmac_clk_in,
  input  wire logic                                 ext_txmac_clk_in,
  input  wire logic                                 recovered_clk_in,
  input  wire logic                                 rx_data_present_in,
  input  wire logic                                 status_reset_in,
  input  wire logic                                 reconfig_reset_in,
  output logic                                      txmac_clk_out,
  output logic                                      rxmac_clk_out,
  output logic                                      rx_pcs_ready_out,
  output logic                                      rx_recover_clk_out,
  output logic [31:0]                               rx_recover_freq_hz_out,
  output logic [31:0]                               mac_freq_hz_out,
  output logic                                      status_reset_out,
  output logic                                      reconfig_reset_out,
  output logic [mcrd_pkg::DOMAIN_COUNT-1:0]         domain_rstn_out
);
  import mcrd_pkg::*;

  logic [1:0]                  rst_sync;
  logic                        core_rstn;
  logic                        cfg_valid;
  logic                        cfg_ext_tx;
  logic                        cfg_synce;
  logic                        cfg_four_lane;
  logic                        cfg_reconfig;
  logic [1:0]                  dom_sync [DOMAIN_COUNT];
  mcrd_rx_state_e              rx_state;
  mcrd_rx_state_e              next_rx_state;
  logic [LOCK_CNT_W-1:0]       lock_cnt;
  logic [LOCK_CNT_W-1:0]       next_lock_cnt;

  // the one asynchronous reset clears the whole core
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync <= 2'h0;
    end else if (clk_en_in) begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign core_rstn = rst_sync[1];

  // straps are sampled once after release so a glitch later cannot flip the clock source
  always_ff @(posedge clock_in or negedge core_rstn) begin
    if (!core_rstn) begin
      cfg_valid     <= 1'b0;
      cfg_ext_tx    <= 1'b0;
      cfg_synce     <= 1'b0;
      cfg_four_lane <= 1'b0;
      cfg_reconfig  <= 1'b0;
    end else if (clk_en_in && !cfg_valid) begin
      cfg_valid     <= 1'b1;
      cfg_ext_tx    <= ext_txmac_pll_in;
      cfg_synce     <= sync_ethernet_option_in;
      cfg_four_lane <= four_lane_in;
      cfg_reconfig  <= reconfig_family_in;
    end
  end

  // each domain gets its own two-stage release, held until straps are known
  generate
    for (genvar d = 0; d < DOMAIN_COUNT; d++) begin : g_dom
      always_ff @(posedge clock_in or negedge core_rstn) begin
        if (!core_rstn) begin
          dom_sync[d] <= 2'h0;
        end else if (clk_en_in) begin
          dom_sync[d] <= {dom_sync[d][0], cfg_valid};
        end
      end
      always_ff @(posedge clock_in or negedge core_rstn) begin
        if (!core_rstn) begin
          domain_rstn_out[d] <= 1'b0;
        end else if (clk_en_in) begin
          domain_rstn_out[d] <= dom_sync[d][1];
        end
      end
    end
  endgenerate

  // transmit clock: internal source unless the external PLL option is strapped
  // the mux output is a sampled level, so it only shows clocks slower than clock_in
  always_ff @(posedge clock_in or negedge core_rstn) begin
    if (!core_rstn) begin
      txmac_clk_out <= 1'b0;
    end else if (clk_en_in) begin
      if (!dom_sync[DOM_TX][1]) begin
        txmac_clk_out <= 1'b0;
      end else if (cfg_ext_tx) begin
        txmac_clk_out <= ext_txmac_clk_in;
      end else begin
        txmac_clk_out <= int_txmac_clk_in;
      end
    end
  end

  // receive clock only passes while recovered data is present
  always_ff @(posedge clock_in or negedge core_rstn) begin
    if (!core_rstn) begin
      rxmac_clk_out <= 1'b0;
    end else if (clk_en_in) begin
      rxmac_clk_out <= dom_sync[DOM_RX][1] & rx_data_present_in
                       & recovered_clk_in;
    end
  end

  // readiness needs a run of present data; the user must not trust the clock before it
  always_comb begin
    next_rx_state = rx_state;
    next_lock_cnt = lock_cnt;
    case (rx_state)
      MCRD_RX_IDLE: begin
        next_lock_cnt = '0;
        if (rx_data_present_in && dom_sync[DOM_RX][1]) begin
          next_rx_state = MCRD_RX_LOCKING;
        end
      end
      MCRD_RX_LOCKING: begin
        if (!rx_data_present_in) begin
          next_rx_state = MCRD_RX_IDLE;
        end else if (lock_cnt == LOCK_CNT_W'(RX_LOCK_CYCLES - 1)) begin
          next_rx_state = MCRD_RX_READY;
        end else begin
          next_lock_cnt = lock_cnt + LOCK_CNT_W'(1);
        end
      end
      MCRD_RX_READY: begin
        if (!rx_data_present_in) begin
          next_rx_state = MCRD_RX_IDLE;
        end
      end
      default: begin
        next_rx_state = MCRD_RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge core_rstn) begin
    if (!core_rstn) begin
      rx_state <= MCRD_RX_IDLE;
    end else if (clk_en_in) begin
      rx_state <= next_rx_state;
    end
  end

  // the count restarts whenever data drops, so a flaky link never reaches ready
  always_ff @(posedge clock_in or negedge core_rstn) begin
    if (!core_rstn) begin
      lock_cnt <= '0;
    end else if (clk_en_in) begin
      lock_cnt <= next_lock_cnt;
    end
  end

  // taken from the next state so ready falls on the same edge as the gated clock
  always_ff @(posedge clock_in or negedge core_rstn) begin
    if (!core_rstn) begin
      rx_pcs_ready_out <= 1'b0;
    end else if (clk_en_in) begin
      rx_pcs_ready_out <= (next_rx_state == MCRD_RX_READY);
    end
  end

  // recovered clock is unfiltered; jitter cleanup stays outside the core
  always_ff @(posedge clock_in or negedge core_rstn) begin
    if (!core_rstn) begin
      rx_recover_clk_out <= 1'b0;
    end else if (clk_en_in) begin
      rx_recover_clk_out <= cfg_synce & dom_sync[DOM_RX][1] & recovered_clk_in;
    end
  end

  // rates are reported as words; a single 25 MHz domain cannot carry the clocks
  always_ff @(posedge clock_in or negedge core_rstn) begin
    if (!core_rstn) begin
      mac_freq_hz_out <= FREQ_RESET_VALUE;
    end else if (clk_en_in && cfg_valid) begin
      mac_freq_hz_out <= MAC_FREQ_HZ;
    end
  end

  always_ff @(posedge clock_in or negedge core_rstn) begin
    if (!core_rstn) begin
      rx_recover_freq_hz_out <= FREQ_RESET_VALUE;
    end else if (clk_en_in && cfg_valid) begin
      if (!cfg_synce) begin
        rx_recover_freq_hz_out <= FREQ_RESET_VALUE;
      end else if (cfg_four_lane) begin
        rx_recover_freq_hz_out <= RECOVER_FOUR_LANE_HZ;
      end else begin
        rx_recover_freq_hz_out <= RECOVER_TEN_LANE_HZ;
      end
    end
  end

  // status interface reset, sampled on clock_in, which serves as the status clock
  always_ff @(posedge clock_in or negedge core_rstn) begin
    if (!core_rstn) begin
      status_reset_out <= 1'b1;
    end else if (clk_en_in) begin
      status_reset_out <= status_reset_in | ~dom_sync[DOM_STATUS][1];
    end
  end

  // reconfiguration reset exists only for the one family; otherwise it stays asserted
  always_ff @(posedge clock_in or negedge core_rstn) begin
    if (!core_rstn) begin
      reconfig_reset_out <= 1'b1;
    end else if (clk_en_in) begin
      reconfig_reset_out <= ~cfg_reconfig | reconfig_reset_in
                            | ~dom_sync[DOM_RECONFIG][1];
    end
  end

endmodule

// ---- verilog/mcrd_pkg.sv ----
// Functional notes
// - transmit path clocked from TX MAC clock, 390.625 MHz
// - external PLL option selects external TX clock
// - receive path clocked from RX MAC clock
// - RX MAC clock follows recovered clock, needs data
// - recovered clock output only with sync Ethernet
// - recovered clock 322.265625 or 402.83203 MHz
// - single asynchronous reset resets whole core
// - synchronous status interface reset on status clock
// - reconfiguration reset only in one device family
// - status clock clocks status interface, 100-125 MHz; clock_in serves as it and the testbench runs it at 25 MHz
package mcrd_pkg;
  localparam int unsigned MAC_FREQ_HZ            = 390625000;
  localparam int unsigned RECOVER_TEN_LANE_HZ    = 322265625;
  localparam int unsigned RECOVER_FOUR_LANE_HZ   = 402832030;
  localparam int unsigned STATUS_CLK_MIN_MHZ     = 100;
  localparam int unsigned STATUS_CLK_MAX_MHZ     = 125;
  localparam int unsigned RESET_HOLD_CYCLES      = 10;
  localparam int unsigned RX_LOCK_CYCLES         = 8;
  localparam int unsigned LOCK_CNT_W             = 4;
  localparam int unsigned DOMAIN_COUNT           = 4;
  localparam int unsigned DOM_STATUS             = 0;
  localparam int unsigned DOM_TX                 = 1;
  localparam int unsigned DOM_RX                 = 2;
  localparam int unsigned DOM_RECONFIG           = 3;
  localparam logic [31:0] FREQ_RESET_VALUE       = 32'h0;
  typedef enum logic [1:0] {
    MCRD_RX_IDLE,
    MCRD_RX_LOCKING,
    MCRD_RX_READY
  } mcrd_rx_state_e;
endpackage

// ---- sim/mcrd_top_assertions.sv ----
`timescale 1ns/100ps
module mcrd_top_checker
  import mcrd_pkg::*;
(
  input wire logic        clock_in,
  input wire logic        rstn_in,
  input wire logic        ext_txmac_pll_in,
  input wire logic        sync_ethernet_option_in,
  input wire logic        four_lane_in,
  input wire logic        reconfig_family_in,
  input wire logic        int_txmac_clk_in,
  input wire logic        ext_txmac_clk_in,
  input wire logic        recovered_clk_in,
  input wire logic        rx_data_present_in,
  input wire logic        status_reset_in,
  input wire logic        reconfig_reset_in,
  input wire logic        txmac_clk_out,
  input wire logic        rxmac_clk_out,
  input wire logic        rx_pcs_ready_out,
  input wire logic        rx_recover_clk_out,
  input wire logic        status_reset_out,
  input wire logic        reconfig_reset_out,
  input wire logic [31:0] rx_recover_freq_hz_out,
  input wire logic [31:0] mac_freq_hz_out,
  input wire logic [3:0]  domain_rstn_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  a_tx_clk_select: assert property (domain_rstn_out[1] && $past(domain_rstn_out[1]) |->
    txmac_clk_out == $past(ext_txmac_pll_in ? ext_txmac_clk_in : int_txmac_clk_in))
    else $error("tx clock not from selected source");
  a_rx_clk_gate: assert property (domain_rstn_out[2] && $past(domain_rstn_out[2]) |->
    rxmac_clk_out == $past(recovered_clk_in & rx_data_present_in))
    else $error("rx clock not following recovered clock");
  a_recover_clk_gate: assert property (domain_rstn_out == 4'hF &&
    $past(domain_rstn_out) == 4'hF |->
    rx_recover_clk_out == $past(recovered_clk_in & sync_ethernet_option_in))
    else $error("recovered clock output wrong");
  a_recover_freq: assert property (domain_rstn_out[0] |-> rx_recover_freq_hz_out ==
    (!sync_ethernet_option_in ? 32'h0 : four_lane_in ? RECOVER_FOUR_LANE_HZ : RECOVER_TEN_LANE_HZ))
    else $error("recovered frequency wrong");
  a_mac_freq: assert property (domain_rstn_out[0] |-> mac_freq_hz_out == MAC_FREQ_HZ)
    else $error("mac frequency wrong");
  a_status_reset_follow: assert property (domain_rstn_out[0] &&
    $past(domain_rstn_out[0]) |-> status_reset_out == $past(status_reset_in))
    else $error("status reset not following");
  a_reconfig_reset_map: assert property (domain_rstn_out[3] &&
    $past(domain_rstn_out[3]) |->
    reconfig_reset_out == ($past(reconfig_reset_in) || !reconfig_family_in))
    else $error("reconfig reset wrong");
  a_ready_drop: assert property (!rx_data_present_in |=> !rx_pcs_ready_out)
    else $error("ready kept without data");
  a_ready_lock: assert property ($rose(rx_pcs_ready_out) |-> $past(rx_data_present_in) &&
    $past(rx_data_present_in, 7)) else $error("ready rose too early");
  a_reset_sync: assert property ($rose(rstn_in) |-> (domain_rstn_out == 4'h0) [*4])
    else $error("domain released too early");
endmodule

bind mcrd_top mcrd_top_checker u_chk (.*);

// ---- sim/mcrd_partner.sv ----
`timescale 1ns/100ps
module mcrd_partner (
  input  wire logic clock_in,
  input  wire logic reset_req_in,
  input  wire logic link_up_in,
  output logic      rstn_out,
  output logic      int_clk_out,
  output logic      ext_clk_out,
  output logic      rec_clk_out,
  output logic      data_out
);
  logic [4:0] hold = 5'h14;
  logic [1:0] div = 2'h0;
  // twenty cycles: ten is the floor, the rest lets the fractional_pll lock
  always @(posedge clock_in) begin
    if (reset_req_in)
      hold <= #1 5'h14;
    else if (hold != 5'h00)
      hold <= #1 hold - 5'h01;
    div <= #1 div + 2'h1;
  end
  assign rstn_out    = (hold == 5'h00);
  assign int_clk_out = div[0];
  assign ext_clk_out = div[1];
  // recovered clock stands still without link data; nothing filtered is fed back
  assign rec_clk_out = link_up_in & ~div[0];
  assign data_out    = link_up_in;
endmodule

// ---- sim/mcrd_top_tb.sv ----
`timescale 1ns/100ps
module mcrd_top_tb;
  import mcrd_pkg::*;
  logic clk = 1'b0, req = 1'b0, link = 1'b0, ext = 1'b0, sync = 1'b0, four = 1'b0, fam = 1'b0;
  logic st_rst = 1'b0, rc_rst = 1'b0;
  logic rstn, int_c, ext_c, rec_c, data, tx_c, rx_c, rdy, rcv_c, st_o, rc_o;
  logic [31:0] rfreq, mfreq;
  logic [3:0] dom;
  int fails = 0, n_checks = 0;
  initial forever #20 clk = ~clk;
  mcrd_partner far (.clock_in(clk), .reset_req_in(req), .link_up_in(link), .rstn_out(rstn),
    .int_clk_out(int_c), .ext_clk_out(ext_c), .rec_clk_out(rec_c), .data_out(data));
  mcrd_top dut (.clock_in(clk), .rstn_in(rstn), .clk_en_in(1'b1), .ext_txmac_pll_in(ext),
    .sync_ethernet_option_in(sync), .four_lane_in(four), .reconfig_family_in(fam),
    .int_txmac_clk_in(int_c), .ext_txmac_clk_in(ext_c), .recovered_clk_in(rec_c),
    .rx_data_present_in(data), .status_reset_in(st_rst), .reconfig_reset_in(rc_rst),
    .txmac_clk_out(tx_c), .rxmac_clk_out(rx_c), .rx_pcs_ready_out(rdy),
    .rx_recover_clk_out(rcv_c), .rx_recover_freq_hz_out(rfreq), .mac_freq_hz_out(mfreq),
    .status_reset_out(st_o), .reconfig_reset_out(rc_o), .domain_rstn_out(dom));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // straps only move while the core is held, since they are latched once
  task automatic t_config(input logic [2:0] i);
    req = 1'b1;
    tick();
    req = 1'b0;
    tick();
    {fam, four, sync} = i;
    ext = i[0] ^ i[1];
    check(dom, 4'h0);
    check(mfreq, FREQ_RESET_VALUE);
    for (int k = 0; k < 40 && dom !== 4'hF; k++) tick();
    if (dom !== 4'hF) begin
      fails++;
      end_of_test();
    end
    check(mfreq, MAC_FREQ_HZ);
    check(rfreq, sync ? (four ? RECOVER_FOUR_LANE_HZ : RECOVER_TEN_LANE_HZ) : 32'h0);
    $display("done config %0d", i);
  endtask
  task automatic t_tx_clock();
    logic e;
    repeat (8) begin
      @(posedge clk);
      e = ext ? ext_c : int_c;
      #1;
      check(tx_c, e);
    end
    $display("done tx clock");
  endtask
  task automatic t_rx_lock();
    logic e, r;
    int n;
    link = 1'b1;
    for (n = 0; n < 20 && rdy !== 1'b1; n++) tick();
    check(n, 9);
    if (n == 20) end_of_test();
    repeat (6) begin
      @(posedge clk);
      e = rec_c & data;
      r = rec_c & sync;
      #1;
      check(rx_c, e);
      check(rcv_c, r);
    end
    link = 1'b0;
    tick();
    tick();
    check(rdy, 1'b0);
    check(rx_c, 1'b0);
    $display("done rx lock");
  endtask
  task automatic t_resets();
    st_rst = 1'b1;
    rc_rst = 1'b1;
    tick();
    tick();
    check(st_o, 1'b1);
    check(rc_o, 1'b1);
    st_rst = 1'b0;
    rc_rst = 1'b0;
    tick();
    tick();
    check(st_o, 1'b0);
    check(rc_o, !fam);
    $display("done resets");
  endtask
  initial begin
    tick();
    for (int i = 0; i < 8; i++) begin
      t_config(3'(i));
      t_tx_clock();
      t_rx_lock();
      t_resets();
    end
    end_of_test();
  end
endmodule
